// File: core/tpc_pkg.sv
// package: register map, field positions, reset values and timing constants of the timer
package tpc_pkg;
    // register byte addresses (each register one aligned 32-bit word)
    localparam logic [7:0] ADDR_CTRL_ONE   = 8'h00;
    localparam logic [7:0] ADDR_CTRL_TWO   = 8'h04;
    localparam logic [7:0] ADDR_STATUS     = 8'h08;
    localparam logic [7:0] ADDR_CAP1_HI    = 8'h0c;
    localparam logic [7:0] ADDR_CAP1_LO    = 8'h10;
    localparam logic [7:0] ADDR_CMP1_HI    = 8'h14;
    localparam logic [7:0] ADDR_CMP1_LO    = 8'h18;
    localparam logic [7:0] ADDR_CNT_HI     = 8'h1c;
    localparam logic [7:0] ADDR_CNT_LO     = 8'h20;
    localparam logic [7:0] ADDR_CAP2_HI    = 8'h24;
    localparam logic [7:0] ADDR_CAP2_LO    = 8'h28;
    localparam logic [7:0] ADDR_CMP2_HI    = 8'h2c;
    localparam logic [7:0] ADDR_CMP2_LO    = 8'h30;
    // control one fields
    localparam int CR1_CAP_IRQ_EN  = 7;
    localparam int CR1_CMP_IRQ_EN  = 6;
    localparam int CR1_OVF_IRQ_EN  = 5;
    localparam int CR1_FORCE_TWO   = 4;
    localparam int CR1_FORCE_ONE   = 3;
    localparam int CR1_LEVEL_TWO   = 2;
    localparam int CR1_CAP1_EDGE   = 1;
    localparam int CR1_LEVEL_ONE   = 0;
    // control two fields
    localparam int CR2_PIN1_EN     = 7;
    localparam int CR2_PIN2_EN     = 6;
    localparam int CR2_SINGLE      = 5;
    localparam int CR2_PWM         = 4;
    localparam int CR2_CLK_SEL_HI  = 3;
    localparam int CR2_CLK_SEL_LO  = 2;
    localparam int CR2_CAP2_EDGE   = 1;
    localparam int CR2_GLOBAL_MASK = 0;
    // status fields
    localparam int SR_CAP1_FLAG    = 7;
    localparam int SR_CMP1_FLAG    = 6;
    localparam int SR_OVF_FLAG     = 5;
    localparam int SR_CAP2_FLAG    = 4;
    localparam int SR_CMP2_FLAG    = 3;
    // reset values
    localparam logic [7:0]  CTRL_RESET     = 8'h00;
    localparam logic [7:0]  CMP_HI_RESET   = 8'h80;
    localparam logic [7:0]  CMP_LO_RESET   = 8'h00;
    localparam logic [15:0] COUNT_RESET    = 16'hfffc;
    localparam logic [15:0] PWM_RELOAD     = 16'hfffc;
    // compare value = ticks - this offset
    localparam int          CMP_TICK_OFFSET = 5;
    // clock select codes: divide by 4, 2, 8, external
    localparam logic [1:0]  CLK_DIV4       = 2'h0;
    localparam logic [1:0]  CLK_DIV2       = 2'h1;
    localparam logic [1:0]  CLK_DIV8       = 2'h2;
    localparam logic [1:0]  CLK_EXT        = 2'h3;
    typedef enum logic [1:0] {TPC_IDLE, TPC_ACCESS} tpc_bus_state_t;
endpackage : tpc_pkg

// File: core/tpc_sync_edge.sv
// two-flop synchroniser with rising and falling edge pulses
`timescale 1ns/100ps
`default_nettype none
module tpc_sync_edge (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic pin_in,
    output logic      level_out,
    output logic      rise_out,
    output logic      fall_out
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= pin_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign level_out = sync_q;
    assign rise_out  = sync_q & ~prev_q;
    assign fall_out  = ~sync_q & prev_q;
endmodule : tpc_sync_edge
`default_nettype wire

// File: core/tpc_prescaler.sv
// timer tick source: divided system clock or external clock rising edge
`timescale 1ns/100ps
`default_nettype none
module tpc_prescaler (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic [1:0] clk_sel,
    input  wire logic       ext_rise,
    input  wire logic       restart,
    output logic            tick
);
    logic [2:0] div_q;
    logic       div_end;

    always_ff @(posedge sys_clk) begin
        if (rst || restart) begin
            div_q <= 3'h0;
        end else begin
            div_q <= div_q + 3'h1;
        end
    end

    always_comb begin
        case (clk_sel)
            tpc_pkg::CLK_DIV2: div_end = div_q[0];
            tpc_pkg::CLK_DIV4: div_end = &div_q[1:0];
            tpc_pkg::CLK_DIV8: div_end = &div_q;
            default:           div_end = 1'b0;
        endcase
    end

    assign tick = (clk_sel == tpc_pkg::CLK_EXT) ? ext_rise : div_end;
endmodule : tpc_prescaler
`default_nettype wire

// File: core/tpc_timer.sv
// 16-bit timer with two compares, two captures, pwm mode and an apb register slave
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - pwm mode double-buffers both compare values
// - pwm uses compare one and compare two
// - pwm output takes level per match
// - equal levels give constant output
// - pulse from compare-one to compare-two match
// - compare value is ticks minus five
// - compare-two match reloads counter fffc
// - high byte write inhibits until low
// - no compare flags in pwm mode
// - pwm period end sets capture one flag
// - pwm disconnects capture one, keeps two
// - pwm wins over single pulse
// - first instance: compare two write-only
// - bit 7 enables capture interrupts
// - bit 6 enables compare interrupts
// - bit 5 enables overflow interrupt
// - force bits copy levels to outputs
// - level two drives output two or one
// - bit 1 picks capture one edge
// - level one driven on compare-one match
// - capture one bytes latch counter halves
// - compare bytes match counter bytes
// - counter low write resets; access clears overflow
module tpc_timer #(
    parameter bit FIRST_INSTANCE = 1'b0
) (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        capture_input_one,
    input  wire logic        capture_input_two,
    input  wire logic        ext_timer_clk,
    output logic             compare_output_one,
    output logic             compare_output_two,
    output logic             timer_irq
);
    logic [7:0]  ctrl_one_q;
    logic [7:0]  ctrl_two_q;
    logic [15:0] count_q;
    logic [7:0]  cmp1_hi_q;
    logic [7:0]  cmp1_lo_q;
    logic [7:0]  cmp2_hi_q;
    logic [7:0]  cmp2_lo_q;
    logic [15:0] cmp1_act_q;
    logic [15:0] cmp2_act_q;
    logic        cmp1_inhibit_q;
    logic        cmp2_inhibit_q;
    logic [7:0]  cap1_hi_q;
    logic [7:0]  cap1_lo_q;
    logic [7:0]  cap2_hi_q;
    logic [7:0]  cap2_lo_q;
    logic        cap1_flag_q;
    logic        cap2_flag_q;
    logic        cmp1_flag_q;
    logic        cmp2_flag_q;
    logic        ovf_flag_q;
    logic        status_read_q;
    logic        out1_q;
    logic        out2_q;
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;
    logic        irq_q;

    logic        cap1_rise;
    logic        cap1_fall;
    logic        cap2_rise;
    logic        cap2_fall;
    logic        ext_rise;
    logic        tick;

    tpc_sync_edge u_sync_cap1 (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .pin_in   (capture_input_one),
        .level_out(),
        .rise_out (cap1_rise),
        .fall_out (cap1_fall)
    );
    tpc_sync_edge u_sync_cap2 (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .pin_in   (capture_input_two),
        .level_out(),
        .rise_out (cap2_rise),
        .fall_out (cap2_fall)
    );
    tpc_sync_edge u_sync_ext (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .pin_in   (ext_timer_clk),
        .level_out(),
        .rise_out (ext_rise),
        .fall_out ()
    );

    // bus decode: no wait state, answer in the access cycle after setup
    logic setup;
    logic wr_en;
    assign setup = psel & ~penable;
    assign wr_en = psel & penable & pwrite & pready_q;

    logic cnt_lo_wr;
    assign cnt_lo_wr = wr_en && paddr == tpc_pkg::ADDR_CNT_LO;

    tpc_prescaler u_presc (
        .sys_clk (sys_clk),
        .rst     (rst),
        .clk_sel (ctrl_two_q[tpc_pkg::CR2_CLK_SEL_HI:tpc_pkg::CR2_CLK_SEL_LO]),
        .ext_rise(ext_rise),
        .restart (cnt_lo_wr),
        .tick    (tick)
    );

    logic pwm_mode, single_mode;
    assign pwm_mode    = ctrl_two_q[tpc_pkg::CR2_PWM];
    assign single_mode = ctrl_two_q[tpc_pkg::CR2_SINGLE] & ~pwm_mode;

    // compare values in use: shadows in pwm mode, live registers otherwise
    logic [15:0] cmp1_val, cmp2_val;
    assign cmp1_val = pwm_mode ? cmp1_act_q : {cmp1_hi_q, cmp1_lo_q};
    assign cmp2_val = pwm_mode ? cmp2_act_q : {cmp2_hi_q, cmp2_lo_q};

    // high byte against counter high, low byte against counter low
    logic match1, match2;
    assign match1 = tick && !cmp1_inhibit_q && count_q[15:8] == cmp1_val[15:8]
                    && count_q[7:0] == cmp1_val[7:0];
    assign match2 = tick && !cmp2_inhibit_q && count_q[15:8] == cmp2_val[15:8]
                    && count_q[7:0] == cmp2_val[7:0];

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            count_q <= tpc_pkg::COUNT_RESET;
        end else if (cnt_lo_wr) begin
            count_q <= tpc_pkg::COUNT_RESET;
        end else if (pwm_mode && match2) begin
            count_q <= tpc_pkg::PWM_RELOAD;
        end else if (tick) begin
            count_q <= count_q + 16'h0001;
        end
    end

    // shadow update at the end of each pwm period keeps the output clean
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cmp1_act_q <= {tpc_pkg::CMP_HI_RESET, tpc_pkg::CMP_LO_RESET};
            cmp2_act_q <= {tpc_pkg::CMP_HI_RESET, tpc_pkg::CMP_LO_RESET};
        end else if (!pwm_mode || match2) begin
            cmp1_act_q <= {cmp1_hi_q, cmp1_lo_q};
            cmp2_act_q <= {cmp2_hi_q, cmp2_lo_q};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cmp1_hi_q      <= tpc_pkg::CMP_HI_RESET;
            cmp1_lo_q      <= tpc_pkg::CMP_LO_RESET;
            cmp2_hi_q      <= tpc_pkg::CMP_HI_RESET;
            cmp2_lo_q      <= tpc_pkg::CMP_LO_RESET;
            cmp1_inhibit_q <= 1'b0;
            cmp2_inhibit_q <= 1'b0;
            ctrl_one_q     <= tpc_pkg::CTRL_RESET;
            ctrl_two_q     <= tpc_pkg::CTRL_RESET;
        end else if (wr_en) begin
            case (paddr)
                tpc_pkg::ADDR_CTRL_ONE: ctrl_one_q <= pwdata[7:0];
                tpc_pkg::ADDR_CTRL_TWO: ctrl_two_q <= pwdata[7:0];
                tpc_pkg::ADDR_CMP1_HI: begin
                    cmp1_hi_q      <= pwdata[7:0];
                    cmp1_inhibit_q <= 1'b1;
                end
                tpc_pkg::ADDR_CMP1_LO: begin
                    cmp1_lo_q      <= pwdata[7:0];
                    cmp1_inhibit_q <= 1'b0;
                end
                tpc_pkg::ADDR_CMP2_HI: begin
                    cmp2_hi_q      <= pwdata[7:0];
                    cmp2_inhibit_q <= 1'b1;
                end
                tpc_pkg::ADDR_CMP2_LO: begin
                    cmp2_lo_q      <= pwdata[7:0];
                    cmp2_inhibit_q <= 1'b0;
                end
                default: ;
            endcase
        end
    end

    // capture one is cut off from the timer in pwm mode
    logic cap1_evt, cap2_evt;
    assign cap1_evt = !pwm_mode && (ctrl_one_q[tpc_pkg::CR1_CAP1_EDGE] ? cap1_rise
                                                                        : cap1_fall);
    assign cap2_evt = !FIRST_INSTANCE && (ctrl_two_q[tpc_pkg::CR2_CAP2_EDGE] ? cap2_rise
                                                                             : cap2_fall);

    always_ff @(posedge sys_clk) begin
        if (cap1_evt) begin
            cap1_hi_q <= count_q[15:8];
            cap1_lo_q <= count_q[7:0];
        end
        if (cap2_evt) begin
            cap2_hi_q <= count_q[15:8];
            cap2_lo_q <= count_q[7:0];
        end
    end

    // flags clear by reading status then accessing the matching low byte; a set wins
    logic clr_access, cap1_clr, cap2_clr, cmp1_clr, cmp2_clr, ovf_clr;
    assign clr_access = status_read_q & psel & penable & pready_q;
    assign cap1_clr   = clr_access && paddr == tpc_pkg::ADDR_CAP1_LO;
    assign cap2_clr   = clr_access && paddr == tpc_pkg::ADDR_CAP2_LO;
    assign cmp1_clr   = clr_access && paddr == tpc_pkg::ADDR_CMP1_LO;
    assign cmp2_clr   = clr_access && paddr == tpc_pkg::ADDR_CMP2_LO;
    assign ovf_clr    = clr_access && paddr == tpc_pkg::ADDR_CNT_LO;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            status_read_q <= 1'b0;
        end else if (psel && penable && pready_q) begin
            status_read_q <= !pwrite && paddr == tpc_pkg::ADDR_STATUS;
        end
    end

    logic ovf_evt;
    assign ovf_evt = tick && count_q == 16'hffff && !(pwm_mode && match2);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cap1_flag_q <= 1'b0;
            cap2_flag_q <= 1'b0;
            cmp1_flag_q <= 1'b0;
            cmp2_flag_q <= 1'b0;
            ovf_flag_q  <= 1'b0;
        end else begin
            cap1_flag_q <= cap1_evt || (pwm_mode && match2) || (cap1_flag_q && !cap1_clr);
            cap2_flag_q <= !FIRST_INSTANCE && (cap2_evt || (cap2_flag_q && !cap2_clr));
            cmp1_flag_q <= (match1 && !pwm_mode) || (cmp1_flag_q && !cmp1_clr);
            cmp2_flag_q <= (match2 && !pwm_mode) || (cmp2_flag_q && !cmp2_clr);
            ovf_flag_q  <= ovf_evt || (ovf_flag_q && !ovf_clr);
        end
    end

    // compare output levels
    logic pin1_en, pin2_en, lvl1, lvl2;
    assign pin1_en = ctrl_two_q[tpc_pkg::CR2_PIN1_EN];
    assign pin2_en = ctrl_two_q[tpc_pkg::CR2_PIN2_EN];
    assign lvl1    = ctrl_one_q[tpc_pkg::CR1_LEVEL_ONE];
    assign lvl2    = ctrl_one_q[tpc_pkg::CR1_LEVEL_TWO];

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            out1_q <= 1'b0;
        end else if (pin1_en) begin
            if (pwm_mode && lvl1 == lvl2) begin
                out1_q <= lvl1;
            end else if (pwm_mode && match2) begin
                out1_q <= lvl2;
            end else if (single_mode && match2) begin
                out1_q <= lvl2;
            end else if (match1) begin
                out1_q <= lvl1;
            end else if (ctrl_one_q[tpc_pkg::CR1_FORCE_ONE]) begin
                out1_q <= lvl1;
            end
        end
    end

    // in pwm and single pulse modes compare two no longer reaches output two
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            out2_q <= 1'b0;
        end else if (pin2_en) begin
            if (match2 && !pwm_mode && !single_mode) begin
                out2_q <= lvl2;
            end else if (ctrl_one_q[tpc_pkg::CR1_FORCE_TWO]) begin
                out2_q <= lvl2;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= !ctrl_two_q[tpc_pkg::CR2_GLOBAL_MASK] &&
                     ((ctrl_one_q[tpc_pkg::CR1_CAP_IRQ_EN] && (cap1_flag_q || cap2_flag_q)) ||
                      (ctrl_one_q[tpc_pkg::CR1_CMP_IRQ_EN] && (cmp1_flag_q || cmp2_flag_q)) ||
                      (ctrl_one_q[tpc_pkg::CR1_OVF_IRQ_EN] && ovf_flag_q));
        end
    end

    // read mux
    logic [7:0] rd_byte;
    logic       rd_hit;
    always_comb begin
        rd_hit  = 1'b1;
        rd_byte = 8'h00;
        case (paddr)
            tpc_pkg::ADDR_CTRL_ONE: rd_byte = ctrl_one_q;
            tpc_pkg::ADDR_CTRL_TWO: rd_byte = ctrl_two_q;
            tpc_pkg::ADDR_STATUS:   rd_byte = {cap1_flag_q, cmp1_flag_q, ovf_flag_q,
                                               cap2_flag_q, cmp2_flag_q, 3'h0};
            tpc_pkg::ADDR_CAP1_HI:  rd_byte = cap1_hi_q;
            tpc_pkg::ADDR_CAP1_LO:  rd_byte = cap1_lo_q;
            tpc_pkg::ADDR_CMP1_HI:  rd_byte = cmp1_hi_q;
            tpc_pkg::ADDR_CMP1_LO:  rd_byte = cmp1_lo_q;
            tpc_pkg::ADDR_CNT_HI:   rd_byte = count_q[15:8];
            tpc_pkg::ADDR_CNT_LO:   rd_byte = count_q[7:0];
            tpc_pkg::ADDR_CAP2_HI:  rd_byte = FIRST_INSTANCE ? 8'h00 : cap2_hi_q;
            tpc_pkg::ADDR_CAP2_LO:  rd_byte = FIRST_INSTANCE ? 8'h00 : cap2_lo_q;
            // write-only on the first instance: reads give no meaningful data
            tpc_pkg::ADDR_CMP2_HI:  rd_byte = FIRST_INSTANCE ? 8'h00 : cmp2_hi_q;
            tpc_pkg::ADDR_CMP2_LO:  rd_byte = FIRST_INSTANCE ? 8'h00 : cmp2_lo_q;
            default:                rd_hit  = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= setup;
            pslverr_q <= setup & ~rd_hit;
            prdata_q  <= (setup && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end

    assign prdata             = prdata_q;
    assign pready             = pready_q;
    assign pslverr            = pslverr_q;
    assign compare_output_one = out1_q;
    assign compare_output_two = out2_q;
    assign timer_irq          = irq_q;
endmodule : tpc_timer
`default_nettype wire

// File: verification/tpc_pins.sv
// pin-side model: capture pin drivers and external timer clock source
`timescale 1ns/100ps
`default_nettype none
module tpc_pins (
    input  wire logic sys_clk,
    input  wire logic compare_output_one,
    input  wire logic compare_output_two,
    output logic      capture_input_one,
    output logic      capture_input_two,
    output logic      ext_timer_clk
);
    logic [2:0] div_q = 3'h0;
    initial begin
        capture_input_one = 1'b0;
        capture_input_two = 1'b0;
    end
    // free-running at one eighth of the system rate, slow enough for the synchroniser
    always @(posedge sys_clk) begin
        div_q <= div_q + 3'h1;
    end
    assign ext_timer_clk = div_q[2];
    // pin edges move only just after a clock edge
    task automatic set_pin(input logic one, input logic v);
        @(posedge sys_clk);
        if (one)
            capture_input_one <= v;
        else
            capture_input_two <= v;
    endtask
endmodule // tpc_pins
`default_nettype wire

// File: verification/tpc_timer_asserts.sv
// checker: bus answer and output relations at the timer ports
`timescale 1ns/100ps
`default_nettype none
module tpc_timer_asserts (
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        compare_output_one,
    input wire logic        compare_output_two,
    input wire logic        timer_irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence answer_s;
        pready ##1 !pready;
    endsequence
    ready_after_setup_a: assert property (setup_s |=> answer_s)
        else $error("no single-cycle ready after setup");
    ready_in_access_a: assert property (pready |-> psel && penable && $past(psel && !penable))
        else $error("ready outside an access cycle");
    idle_rdata_zero_a: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside the answer cycle");
    upper_rdata_zero_a: assert property (prdata[31:8] == 24'h0)
        else $error("read data above the byte not zero");
    unmapped_error_a: assert property (psel && !penable && paddr > 8'h30 |=> pslverr)
        else $error("unmapped address not refused");
    mapped_no_error_a: assert property (psel && !penable && paddr <= 8'h30 && paddr[1:0] == 2'h0
        |=> !pslverr)
        else $error("mapped address refused");
    error_data_zero_a: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error answer carries data");
    reset_quiet_a: assert property ($fell(rst) |-> !compare_output_one && !compare_output_two
        && !timer_irq)
        else $error("outputs active after reset");
endmodule // tpc_timer_asserts
bind tpc_timer tpc_timer_asserts u_chk (.sys_clk(sys_clk), .rst(rst), .psel(psel),
    .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .compare_output_one(compare_output_one), .compare_output_two(compare_output_two),
    .timer_irq(timer_irq));
`default_nettype wire

// File: verification/timer_pwm_compare_capture_tb_top.sv
// testbench: register map, pwm waveform, force, capture and overflow scenarios
`timescale 1ns/100ps
`default_nettype none
module timer_pwm_compare_capture_tb_top;
    logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic        cap_one, cap_two, ext_clk, out_one, out_two, timer_irq;
    int          n_fail = 0;
    int          total_checks = 0;
    int          cycles = 0;
    localparam int CMP1 = 16;
    localparam int CMP2 = 48;

    tpc_timer dut (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .capture_input_one(cap_one), .capture_input_two(cap_two),
        .ext_timer_clk(ext_clk), .compare_output_one(out_one), .compare_output_two(out_two),
        .timer_irq(timer_irq));
    tpc_pins pins (.sys_clk(sys_clk), .compare_output_one(out_one),
        .compare_output_two(out_two), .capture_input_one(cap_one),
        .capture_input_two(cap_two), .ext_timer_clk(ext_clk));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic results;
        if (n_fail == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // one transfer; an idle cycle follows so the next setup never lands in the same step
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] r, output logic e);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        if (n >= 100)
            n_fail++;
        r = prdata[7:0];
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        logic       e;
        apb(1'b1, a, d, r, e);
    endtask

    // a zero mask makes this a plain access, as the flag-clearing sequences need
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] msk);
        logic [7:0] r;
        logic       e;
        apb(1'b0, a, 8'h00, r, e);
        if (msk != 8'h00)
            chk({24'h0, r & msk}, {24'h0, exp & msk});
    endtask

    task automatic wait_one(input logic v, output int n);
        n = 0;
        while (out_one !== v && n < 2000) begin
            @(posedge sys_clk);
            n++;
        end
    endtask

    task automatic wait_irq;
        int n;
        n = 0;
        while (timer_irq !== 1'b1 && n < 300) begin
            @(posedge sys_clk);
            n++;
        end
    endtask

    task automatic t_reset_map;
        logic [7:0] r;
        logic       e;
        rd(tpc_pkg::ADDR_CTRL_ONE, tpc_pkg::CTRL_RESET, 8'hff);
        rd(tpc_pkg::ADDR_CMP1_HI, tpc_pkg::CMP_HI_RESET, 8'hff);
        rd(tpc_pkg::ADDR_CMP1_LO, tpc_pkg::CMP_LO_RESET, 8'hff);
        rd(tpc_pkg::ADDR_CMP2_HI, tpc_pkg::CMP_HI_RESET, 8'hff);
        rd(tpc_pkg::ADDR_CMP2_LO, tpc_pkg::CMP_LO_RESET, 8'hff);
        wr(tpc_pkg::ADDR_CTRL_ONE, 8'h5a);
        rd(tpc_pkg::ADDR_CTRL_ONE, 8'h5a, 8'hff);
        wr(tpc_pkg::ADDR_CTRL_ONE, 8'h00);
        apb(1'b0, 8'h34, 8'h00, r, e);
        chk({31'h0, e}, 32'h1);
        chk({24'h0, r}, 32'h0);
    endtask

    task automatic t_pwm;
        int h, l, z;
        wr(tpc_pkg::ADDR_CMP2_HI, 8'h00);
        wr(tpc_pkg::ADDR_CMP2_LO, 8'(CMP2));
        wr(tpc_pkg::ADDR_CMP1_HI, 8'h00);
        wr(tpc_pkg::ADDR_CMP1_LO, 8'(CMP1));
        wr(tpc_pkg::ADDR_CTRL_ONE, 8'h01);
        wr(tpc_pkg::ADDR_CTRL_TWO, 8'hb4);
        wr(tpc_pkg::ADDR_CNT_LO, 8'h00);
        wait_one(1'b0, h);
        wait_one(1'b1, h);
        wait_one(1'b0, h);
        wait_one(1'b1, l);
        chk(32'(h), 32'((CMP2 - CMP1) * 2));
        chk(32'(h + l), 32'((CMP2 + tpc_pkg::CMP_TICK_OFFSET) * 2));
        wr(tpc_pkg::ADDR_CTRL_ONE, 8'h05);
        repeat (250) @(posedge sys_clk);
        z = 0;
        repeat (250) begin
            @(posedge sys_clk);
            if (out_one !== 1'b1)
                z++;
        end
        chk(32'(z), 32'h0);
        wr(tpc_pkg::ADDR_CTRL_ONE, 8'h41);
        repeat (250) @(posedge sys_clk);
        chk({31'h0, timer_irq}, 32'h0);
        pins.set_pin(1'b0, 1'b1);
        pins.set_pin(1'b0, 1'b0);
        wr(tpc_pkg::ADDR_CTRL_ONE, 8'h81);
        wait_irq();
        chk({31'h0, timer_irq}, 32'h1);
        rd(tpc_pkg::ADDR_STATUS, 8'h90, 8'hd8);
        wr(tpc_pkg::ADDR_CTRL_ONE, 8'h00);
    endtask

    task automatic t_force;
        wr(tpc_pkg::ADDR_CTRL_TWO, 8'h40);
        wr(tpc_pkg::ADDR_CTRL_ONE, 8'h14);
        repeat (3) @(posedge sys_clk);
        chk({31'h0, out_two}, 32'h1);
        wr(tpc_pkg::ADDR_CTRL_ONE, 8'h10);
        repeat (3) @(posedge sys_clk);
        chk({31'h0, out_two}, 32'h0);
    endtask

    task automatic t_capture;
        wr(tpc_pkg::ADDR_CTRL_TWO, 8'h02);
        wr(tpc_pkg::ADDR_CTRL_ONE, 8'h00);
        rd(tpc_pkg::ADDR_STATUS, 8'h00, 8'h00);
        rd(tpc_pkg::ADDR_CAP1_LO, 8'h00, 8'h00);
        rd(tpc_pkg::ADDR_STATUS, 8'h10, 8'h90);
        rd(tpc_pkg::ADDR_CAP2_LO, 8'h00, 8'h00);
        pins.set_pin(1'b1, 1'b1);
        pins.set_pin(1'b0, 1'b1);
        repeat (8) @(posedge sys_clk);
        rd(tpc_pkg::ADDR_STATUS, 8'h10, 8'h90);
        wr(tpc_pkg::ADDR_CNT_LO, 8'h00);
        pins.set_pin(1'b1, 1'b0);
        repeat (8) @(posedge sys_clk);
        rd(tpc_pkg::ADDR_STATUS, 8'h90, 8'h90);
        rd(tpc_pkg::ADDR_CAP1_HI, tpc_pkg::COUNT_RESET[15:8], 8'hff);
        rd(tpc_pkg::ADDR_CAP1_LO, tpc_pkg::COUNT_RESET[7:0], 8'hfc);
    endtask

    task automatic t_overflow;
        wr(tpc_pkg::ADDR_CTRL_TWO, 8'h04);
        wr(tpc_pkg::ADDR_CMP1_HI, 8'h00);
        rd(tpc_pkg::ADDR_STATUS, 8'h00, 8'h00);
        rd(tpc_pkg::ADDR_CMP1_LO, 8'h00, 8'h00);
        rd(tpc_pkg::ADDR_STATUS, 8'h00, 8'h00);
        rd(tpc_pkg::ADDR_CNT_LO, 8'h00, 8'h00);
        wr(tpc_pkg::ADDR_CTRL_ONE, 8'h20);
        chk({31'h0, timer_irq}, 32'h0);
        wr(tpc_pkg::ADDR_CNT_LO, 8'h00);
        wait_irq();
        chk({31'h0, timer_irq}, 32'h1);
        rd(tpc_pkg::ADDR_STATUS, 8'h20, 8'h20);
        rd(tpc_pkg::ADDR_CNT_LO, 8'h00, 8'h00);
        repeat (2) @(posedge sys_clk);
        chk({31'h0, timer_irq}, 32'h0);
        repeat (40) @(posedge sys_clk);
        rd(tpc_pkg::ADDR_STATUS, 8'h00, 8'h40);
        wr(tpc_pkg::ADDR_CMP1_LO, 8'(CMP1));
        wr(tpc_pkg::ADDR_CNT_LO, 8'h00);
        repeat (60) @(posedge sys_clk);
        rd(tpc_pkg::ADDR_STATUS, 8'h40, 8'h40);
    endtask

    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        t_reset_map();
        t_pwm();
        t_force();
        t_capture();
        t_overflow();
        results();
    end

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            results();
        end
    end
endmodule // timer_pwm_compare_capture_tb_top
`default_nettype wire
